//--- verilog/pin_cfg_pkg.sv
// Purpose: shared constants and carriers for the multi-function pin block
// Assumes: 16-bit register words reached through a simple internal register port
// Notes: offsets are register addresses of the serial map
package pin_cfg_pkg;
  localparam logic [7:0] PIN_CFG_ADDR = 8'h24;
  localparam logic [7:0] COMPARATOR_PROTECT_STATUS_ADDR = 8'h23;
  localparam logic [7:0] MAP_UNLOCK_ADDR = 8'hE0;
  localparam logic [15:0] PIN_CFG_RESET = 16'h0000;
  localparam logic [15:0] MAP_UNLOCK_KEY_VALUE = 16'h5A5A;
  // field positions of pin_function_config
  localparam int DEGLITCH_BIT = 15;
  localparam int DRIVE_ON_BIT = 13;
  localparam int SOURCE_LSB = 9;
  localparam int MASK_LSB = 5;
  localparam int FUNC_LSB = 1;
  localparam int SENSE_ON_BIT = 0;
  // field positions of comparator_protect_status
  localparam int PROTECT_BIT = 8;
  localparam int WIN0_BIT = 7;
  localparam int WIN1_BIT = 4;
  localparam int CMP0_BIT = 3;
  localparam int CMP1_BIT = 0;
  // deglitch filter length in clock cycles
  localparam int DEGLITCH_CYCLES = 4;
  typedef enum logic [3:0] {
    SRC_NV_BUSY = 4'h1,
    SRC_CH1_BUSY = 4'h4,
    SRC_CH0_BUSY = 4'h7,
    SRC_CH1_WIN = 4'h8,
    SRC_CH0_WIN = 4'hB
  } drive_source_t;
  typedef enum logic [3:0] {
    FN_FAULT_DUMP = 4'h2,
    FN_IOUT_PWR = 4'h3,
    FN_VOUT_PWR = 4'h4,
    FN_PROTECT = 4'h5,
    FN_CLEAR = 4'h7,
    FN_LOAD = 4'h8,
    FN_WAVE = 4'h9,
    FN_MARGIN = 4'hA,
    FN_RESET = 4'hB,
    FN_NV_PROTECT = 4'hC,
    FN_MAP_LOCK = 4'hD
  } input_function_t;
  // per-channel internal status, index 0 = channel 0
  typedef struct packed {
    logic [1:0] busy;
    logic [1:0] window_compare_out;
    logic [1:0] compare_raw;
  } channel_status_t;
  // actions driven to the rest of the device
  typedef struct packed {
    logic fault_dump;
    logic protect_start;
    logic clear_request;
    logic device_reset;
    logic [1:0] iout_down;
    logic [1:0] iout_up;
    logic [1:0] vout_down;
    logic [1:0] vout_up;
    logic [1:0] load_update_strobe;
    logic [1:0] wave_start;
    logic [1:0] wave_stop;
    logic [1:0] margin_low;
    logic [1:0] margin_high;
  } pin_action_t;
endpackage

//--- verilog/pin_deglitch.sv
// Purpose: optional glitch filter for the synchronised pin level
// Assumes: input already synchronised to clk
// Notes: output follows input only after a stable run when enabled
`timescale 1ns/1ps
module pin_deglitch
  import pin_cfg_pkg::*;
#(
  parameter int STABLE_CYCLES = DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level in and out
  input wire logic enable,
  input wire logic level_in,
  output logic level_out
);
  // the counter is eight bits wide, so longer runs cannot be served
  if (STABLE_CYCLES < 1 || STABLE_CYCLES > 255) begin : g_bad_cycles
    $error("STABLE_CYCLES out of range");
  end
  logic [7:0] count_reg, count_next;
  logic level_reg, level_next;
  always_comb begin
    count_next = count_reg;
    level_next = level_reg;
    if (!enable) begin
      // raw path: fastest response
      level_next = level_in;
      count_next = 8'h00;
    end else if (level_in == level_reg) begin
      count_next = 8'h00;
    end else if (count_reg == 8'(STABLE_CYCLES - 1)) begin
      level_next = level_in;
      count_next = 8'h00;
    end else begin
      count_next = count_reg + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 8'h00;
      level_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      level_reg <= level_next;
    end
  end
  assign level_out = level_reg;
endmodule

//--- verilog/multi_function_gpio_config.sv
// Purpose: configuration, input functions and output mux of one multi-function pin, plus comparator status
// Assumes: one 10 MHz clock; register port is a simple single-cycle read/write strobe interface
// Notes: serial front end, converter and non-volatile store live elsewhere
`timescale 1ns/1ps
module multi_function_gpio_config
  import pin_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr_via_i2c,
  output logic [15:0] reg_rdata,
  output logic map_locked,
  // stored configuration from nonvolatile memory at reset release
  input wire logic nv_cfg_valid,
  input wire logic [15:0] nv_cfg_word,
  // internal device status
  input wire channel_status_t chan_status,
  input wire logic nonvolatile_busy,
  input wire logic window_latch_on,
  input wire logic window_clear,
  input wire logic protect_active,
  // the pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // actions to the device
  output pin_action_t pin_action,
  output logic nv_program_allowed
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // the pin idles high, so the chain resets high and reset release is not an edge
  logic pin_s1_reg, pin_s2_reg;
  logic [1:0] cmp_s1_reg, cmp_s2_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      cmp_s1_reg <= 2'h0;
      cmp_s2_reg <= 2'h0;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      cmp_s1_reg <= chan_status.compare_raw;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [15:0] cfg_reg, cfg_next;
  logic lock_reg, lock_next;
  logic nv_prog_reg, nv_prog_next;
  logic boot_reg, boot_next;
  logic cfg_hit, unlock_hit, status_hit;
  logic pin_level, pin_prev_reg, fall, rise;
  logic [3:0] func;
  logic [1:0] chan_sel;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign cfg_hit = reg_addr == PIN_CFG_ADDR;
  assign status_hit = reg_addr == COMPARATOR_PROTECT_STATUS_ADDR;
  assign unlock_hit = reg_addr == MAP_UNLOCK_ADDR;
  assign func = cfg_reg[FUNC_LSB +: 4];
  // channel index 0 from mask bit 3, channel 1 from mask bit 0
  assign chan_sel = {cfg_reg[MASK_LSB], cfg_reg[MASK_LSB + 3]};
  // edges are taken after the filter so a rejected glitch never becomes an action
  assign fall = pin_prev_reg & ~pin_level;
  assign rise = ~pin_prev_reg & pin_level;

  // ----------------------------------------------------------------
  // pin filter
  // ----------------------------------------------------------------
  // the filter sits behind the synchroniser, so its counter never sees a metastable level
  pin_deglitch #(
    .STABLE_CYCLES(DEGLITCH_CYCLES)
  ) u_deglitch (
    .clk(clk),
    .rstn(rstn),
    .enable(cfg_reg[DEGLITCH_BIT]),
    .level_in(pin_s2_reg),
    .level_out(pin_level)
  );

  function automatic logic func_active(input logic [3:0] code, input logic [3:0] f, input logic sense);
    func_active = sense && (code == f);
  endfunction

  // one action bit per selected channel; an unselected channel never sees the edge
  function automatic logic [1:0] on_channels(input logic hit, input logic [1:0] sel);
    on_channels = {2{hit}} & sel;
  endfunction

  // ----------------------------------------------------------------
  // configuration, lock and nonvolatile programming state
  // ----------------------------------------------------------------
  // boot_reg marks the first edge after reset, so stored contents are applied only once
  always_comb begin
    cfg_next = cfg_reg;
    lock_next = lock_reg;
    nv_prog_next = nv_prog_reg;
    boot_next = 1'b0;
    // caught once after reset release: only the reset function is restored
    if (boot_reg && nv_cfg_valid && nv_cfg_word[FUNC_LSB +: 4] == FN_RESET) begin
      cfg_next = nv_cfg_word;
    end
    // a write on the first edge after reset overrides the stored word
    if (reg_write && cfg_hit && !lock_reg) begin
      cfg_next = reg_wdata;
    end
    // the key is honoured even while locked, or software could never reopen the map
    if (reg_write && unlock_hit && reg_wdata == MAP_UNLOCK_KEY_VALUE) begin
      lock_next = 1'b0;
    end
    if (func_active(func, FN_MAP_LOCK, cfg_reg[SENSE_ON_BIT])) begin
      if (fall) begin
        lock_next = 1'b0;
      end else if (rise) begin
        lock_next = 1'b1;
      end
    end
    if (func_active(func, FN_NV_PROTECT, cfg_reg[SENSE_ON_BIT])) begin
      if (fall) begin
        nv_prog_next = 1'b1;
      end else if (rise) begin
        nv_prog_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= PIN_CFG_RESET;
      lock_reg <= 1'b0;
      nv_prog_reg <= 1'b1;
      boot_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
    end else begin
      cfg_reg <= cfg_next;
      lock_reg <= lock_next;
      nv_prog_reg <= nv_prog_next;
      boot_reg <= boot_next;
      pin_prev_reg <= pin_level;
    end
  end

  // ----------------------------------------------------------------
  // input function decode
  // ----------------------------------------------------------------
  // registered so each edge action leaves as a clean one-cycle pulse; device_reset is held until the rising edge, clear_request while the pin is low
  pin_action_t act_next, act_reg;
  always_comb begin
    act_next = '0;
    if (cfg_reg[SENSE_ON_BIT]) begin
      unique case (func)
        FN_FAULT_DUMP: act_next.fault_dump = fall;
        FN_IOUT_PWR: begin
          act_next.iout_down = on_channels(fall, chan_sel);
          act_next.iout_up = on_channels(rise, chan_sel);
        end
        FN_VOUT_PWR: begin
          act_next.vout_down = on_channels(fall, chan_sel);
          act_next.vout_up = on_channels(rise, chan_sel);
        end
        FN_PROTECT: act_next.protect_start = fall;
        FN_CLEAR: act_next.clear_request = ~pin_level;
        FN_LOAD: act_next.load_update_strobe = on_channels(fall, chan_sel);
        FN_WAVE: begin
          act_next.wave_start = on_channels(rise, chan_sel);
          act_next.wave_stop = on_channels(fall, chan_sel);
        end
        FN_MARGIN: begin
          act_next.margin_low = on_channels(fall, chan_sel);
          act_next.margin_high = on_channels(rise, chan_sel);
        end
        // held from falling edge until rising edge
        FN_RESET: act_next.device_reset = fall | (act_reg.device_reset & ~rise);
        // handled by lock and nonvolatile state above; others do nothing
        default: act_next = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status word and output mux
  // ----------------------------------------------------------------
  logic protect_reg, protect_next;
  logic [1:0] win_reg, win_next;
  logic pin_out_next;
  logic [15:0] rdata_next, rdata_reg;
  logic [15:0] status_word;

  always_comb begin
    // unused bits read as zero
    status_word = 16'h0000;
    status_word[PROTECT_BIT] = protect_reg;
    status_word[WIN0_BIT] = win_reg[0];
    status_word[WIN1_BIT] = win_reg[1];
    status_word[CMP0_BIT] = cmp_s2_reg[0];
    status_word[CMP1_BIT] = cmp_s2_reg[1];
  end

  always_comb begin
    protect_next = protect_reg;
    // a read clears, but a protect event in the same cycle wins
    if (reg_read && status_hit) begin
      protect_next = 1'b0;
    end
    if (protect_active || act_reg.protect_start) begin
      protect_next = 1'b1;
    end
    // latched mode keeps a set bit until window_clear, whose cycle reloads the live result
    if (window_latch_on) begin
      win_next = window_clear ? chan_status.window_compare_out : (win_reg | chan_status.window_compare_out);
    end else begin
      win_next = chan_status.window_compare_out;
    end
    unique case (cfg_reg[SOURCE_LSB +: 4])
      SRC_NV_BUSY: pin_out_next = nonvolatile_busy;
      SRC_CH1_BUSY: pin_out_next = chan_status.busy[1];
      SRC_CH0_BUSY: pin_out_next = chan_status.busy[0];
      SRC_CH1_WIN: pin_out_next = win_reg[1];
      SRC_CH0_WIN: pin_out_next = win_reg[0];
      // unsupported selector codes drive a quiet low rather than a stale bit
      default: pin_out_next = 1'b0;
    endcase
    rdata_next = rdata_reg;
    if (reg_read) begin
      if (cfg_hit) begin
        rdata_next = cfg_reg;
      end else if (status_hit) begin
        rdata_next = status_word;
      end else begin
        // unmapped addresses read as zero
        rdata_next = 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // enable follows the next config value so the pin turns around with the register
  logic oe_reg, out_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      protect_reg <= 1'b0;
      win_reg <= 2'h0;
      rdata_reg <= 16'h0000;
      act_reg <= '0;
      oe_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      protect_reg <= protect_next;
      win_reg <= win_next;
      rdata_reg <= rdata_next;
      act_reg <= act_next;
      oe_reg <= cfg_next[DRIVE_ON_BIT];
      out_reg <= pin_out_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pin_oe = oe_reg;
  assign pin_out = out_reg;
  assign pin_action = act_reg;
  assign map_locked = lock_reg;
  assign nv_program_allowed = nv_prog_reg;
endmodule

//--- verif/pin_partner.sv
// Purpose: far-side controller that drives or senses the multi-function pin
// Assumes: the controller drives a plain level and gives way while the block drives
// Notes: the wire level is resolved here and fed back to the block input
`timescale 1ns/1ps
module pin_partner (
  // controller side
  input wire logic drive_level,
  // block side
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  // the block wins while it drives; otherwise the controller's level stands
  assign pin_level = pin_oe ? pin_out : drive_level;
endmodule

//--- verif/pin_cfg_monitor.sv
// Purpose: port-level checks of the multi-function pin block
// Assumes: single clock, asynchronous active-low reset
// Notes: status checks wait for settled inputs so the sync pipeline is not a factor
`timescale 1ns/1ps
module pin_cfg_monitor
  import pin_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched ports
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic map_locked,
  input wire channel_status_t chan_status,
  input wire logic window_latch_on,
  input wire logic protect_active,
  input wire logic pin_oe,
  input wire pin_action_t pin_action
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [2:0] up_cnt;
  wire stat_rd = reg_read && reg_addr == COMPARATOR_PROTECT_STATUS_ADDR;
  wire warm = up_cnt == 3'h7;
  // the synchroniser needs a few edges after reset before status is meaningful
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) up_cnt <= 3'h0;
    else if (!warm) up_cnt <= up_cnt + 3'h1;
  end
  property p_oe_follow;
    reg_write && reg_addr == PIN_CFG_ADDR && !map_locked |=> pin_oe == $past(reg_wdata[DRIVE_ON_BIT]);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin enable does not follow config");
  property p_cmp_sync;
    (warm && $stable(chan_status.compare_raw))[*4] ##0 stat_rd |=>
      reg_rdata[CMP0_BIT] == $past(chan_status.compare_raw[0]) &&
      reg_rdata[CMP1_BIT] == $past(chan_status.compare_raw[1]);
  endproperty
  a_cmp_sync: assert property (p_cmp_sync) else $error("comparator bits wrong");
  property p_win_live;
    (warm && !window_latch_on && $stable(chan_status.window_compare_out))[*4] ##0 stat_rd |=>
      reg_rdata[WIN0_BIT] == $past(chan_status.window_compare_out[0]) &&
      reg_rdata[WIN1_BIT] == $past(chan_status.window_compare_out[1]);
  endproperty
  a_win_live: assert property (p_win_live) else $error("window bits wrong");
  property p_prot_set;
    protect_active[*2] ##0 stat_rd |=> reg_rdata[PROTECT_BIT];
  endproperty
  a_prot_set: assert property (p_prot_set) else $error("protect flag missing");
  property p_prot_clr;
    stat_rd && !protect_active && !pin_action.protect_start ##1 (!protect_active && !pin_action.protect_start)[*2]
      ##0 stat_rd |=> !reg_rdata[PROTECT_BIT];
  endproperty
  a_prot_clr: assert property (p_prot_clr) else $error("protect flag not cleared by read");
  property p_fault_pulse;
    pin_action.fault_dump |=> !pin_action.fault_dump;
  endproperty
  a_fault_pulse: assert property (p_fault_pulse) else $error("fault snapshot not a pulse");
  property p_iout_excl;
    !(|(pin_action.iout_down & pin_action.iout_up));
  endproperty
  a_iout_excl: assert property (p_iout_excl) else $error("current output up and down together");
  property p_margin_excl;
    !(|(pin_action.margin_low & pin_action.margin_high));
  endproperty
  a_margin_excl: assert property (p_margin_excl) else $error("margin low and high together");
endmodule
bind multi_function_gpio_config pin_cfg_monitor mon (.clk, .rstn, .reg_write, .reg_read, .reg_addr, .reg_wdata,
  .reg_rdata, .map_locked, .chan_status, .window_latch_on, .protect_active, .pin_oe, .pin_action);

//--- verif/tb.sv
// Purpose: self-checking bench of the multi-function pin block
// Assumes: 10 MHz clock; pin traffic through the partner model
// Notes: action pulses are gathered over a window long enough for the deglitch delay
`timescale 1ns/1ps
module tb
  import pin_cfg_pkg::*;
();
  logic clk;
  logic rstn;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic map_locked;
  logic [15:0] nv_cfg_word;
  channel_status_t chan_status;
  logic nonvolatile_busy;
  logic window_latch_on;
  logic window_clear;
  logic protect_active;
  logic ext_level;
  logic pin_level;
  logic pin_out;
  logic pin_oe;
  logic nv_program_allowed;
  pin_action_t pin_action;
  pin_action_t seen;
  logic [15:0] rv;
  int mismatches;
  int check_count;
  pin_partner far (.drive_level(ext_level), .pin_out, .pin_oe, .pin_level);
  multi_function_gpio_config dut (.clk, .rstn, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_wr_via_i2c(1'b1),
    .reg_rdata, .map_locked, .nv_cfg_valid(1'b1), .nv_cfg_word, .chan_status, .nonvolatile_busy, .window_latch_on,
    .window_clear, .protect_active, .pin_in(pin_level), .pin_out, .pin_oe, .pin_action, .nv_program_allowed);
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
  endtask
  // collects every action seen after a pin change
  task automatic pin_to(input logic v);
    @(posedge clk);
    ext_level <= v;
    seen = '0;
    repeat (12) begin
      @(negedge clk);
      seen = seen | pin_action;
    end
  endtask
  task automatic reset_with(input logic [15:0] w, input logic [15:0] e);
    @(posedge clk);
    rstn <= 1'b0;
    nv_cfg_word <= w;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(PIN_CFG_ADDR);
    chk(rv, e);
  endtask
  function automatic pin_action_t expect_act(input logic [15:0] w, input logic fall);
    pin_action_t e;
    logic [1:0] ch;
    e = '0;
    ch = {w[MASK_LSB], w[MASK_LSB + 3]};
    if (w[SENSE_ON_BIT]) begin
      case (w[FUNC_LSB +: 4])
        4'h2: e.fault_dump = fall;
        4'h3: {e.iout_down, e.iout_up} = fall ? {ch, 2'h0} : {2'h0, ch};
        4'h4: {e.vout_down, e.vout_up} = fall ? {ch, 2'h0} : {2'h0, ch};
        4'h5: e.protect_start = fall;
        4'h7: e.clear_request = 1'b1;
        4'h8: e.load_update_strobe = fall ? ch : 2'h0;
        4'h9: {e.wave_stop, e.wave_start} = fall ? {ch, 2'h0} : {2'h0, ch};
        4'hA: {e.margin_low, e.margin_high} = fall ? {ch, 2'h0} : {2'h0, ch};
        4'hB: e.device_reset = 1'b1;
        default: e = '0;
      endcase
    end
    return e;
  endfunction
  task automatic edge_scan();
    logic [15:0] words [13] = '{16'h0005, 16'h0127, 16'h0029, 16'h000B, 16'h0011, 16'h0131, 16'h0113, 16'h0135,
      16'h0017, 16'h000F, 16'h0004, 16'h000D, 16'h8005};
    foreach (words[i]) begin
      wr(PIN_CFG_ADDR, words[i]);
      pin_to(1'b0);
      chk(seen, expect_act(words[i], 1'b1));
      pin_to(1'b1);
      chk(seen, expect_act(words[i], 1'b0));
      chk(pin_action, 32'h0);
    end
  endtask
  task automatic glitch(input logic [15:0] w, input logic exp);
    wr(PIN_CFG_ADDR, w);
    @(posedge clk);
    ext_level <= 1'b0;
    repeat (2) @(posedge clk);
    pin_to(1'b1);
    chk(seen.fault_dump, exp);
  endtask
  task automatic drive_scan();
    logic [3:0] srcs [5] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'hB};
    logic [4:0] v;
    for (int i = 0; i < 5; i++) begin
      v = 5'h10 >> i;
      wr(PIN_CFG_ADDR, 16'h2000 | (16'(srcs[i]) << SOURCE_LSB));
      {nonvolatile_busy, chan_status.busy, chan_status.window_compare_out} <= v;
      repeat (4) @(negedge clk);
      chk({pin_oe, pin_out}, 2'b11);
      @(posedge clk);
      {nonvolatile_busy, chan_status.busy, chan_status.window_compare_out} <= ~v;
      repeat (4) @(negedge clk);
      chk({pin_oe, pin_out}, 2'b10);
    end
    wr(PIN_CFG_ADDR, 16'h0000);
    @(negedge clk);
    chk(pin_oe, 1'b0);
  endtask
  task automatic status_test();
    @(posedge clk);
    chan_status <= 6'h09;
    protect_active <= 1'b1;
    repeat (6) @(posedge clk);
    rd(COMPARATOR_PROTECT_STATUS_ADDR);
    chk(rv & 16'h0199, 16'h0118);
    @(posedge clk);
    protect_active <= 1'b0;
    rd(COMPARATOR_PROTECT_STATUS_ADDR);
    rd(COMPARATOR_PROTECT_STATUS_ADDR);
    chk(rv & 16'h0199, 16'h0018);
    rd(8'hE1);
    chk(rv, 16'h0000);
    // latched window: a bit set once stays until window_clear
    @(posedge clk);
    window_latch_on <= 1'b1;
    window_clear <= 1'b1;
    chan_status <= 6'h06;
    @(posedge clk);
    window_clear <= 1'b0;
    chan_status <= 6'h02;
    repeat (4) @(posedge clk);
    rd(COMPARATOR_PROTECT_STATUS_ADDR);
    chk(rv & 16'h0199, 16'h0081);
    @(posedge clk);
    window_clear <= 1'b1;
    @(posedge clk);
    window_clear <= 1'b0;
    window_latch_on <= 1'b0;
    rd(COMPARATOR_PROTECT_STATUS_ADDR);
    chk(rv & 16'h0199, 16'h0001);
  endtask
  task automatic lock_test();
    wr(PIN_CFG_ADDR, 16'h0019);
    pin_to(1'b0);
    pin_to(1'b1);
    chk(nv_program_allowed, 1'b0);
    pin_to(1'b0);
    chk(nv_program_allowed, 1'b1);
    wr(PIN_CFG_ADDR, 16'h001B);
    pin_to(1'b1);
    chk(map_locked, 1'b1);
    wr(PIN_CFG_ADDR, 16'h2000);
    rd(PIN_CFG_ADDR);
    chk(rv, 16'h001B);
    pin_to(1'b0);
    chk(map_locked, 1'b0);
    wr(PIN_CFG_ADDR, 16'h0000);
    pin_to(1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    {reg_write, reg_read, reg_addr, reg_wdata, nv_cfg_word} = '0;
    {chan_status, nonvolatile_busy, window_latch_on, window_clear, protect_active} = '0;
    ext_level = 1'b1;
    reset_with(16'h0000, PIN_CFG_RESET);
    chk({map_locked, nv_program_allowed}, 2'b01);
    drive_scan();
    edge_scan();
    glitch(16'h8005, 1'b0);
    glitch(16'h0005, 1'b1);
    status_test();
    lock_test();
    reset_with(16'h0017, 16'h0017);
    reset_with(16'h0005, PIN_CFG_RESET);
    wrap_up();
  end
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule
